// [rtl/gyr_cfg.svh]
// offsets, field positions, identity values and timing counts of the readout bank
`ifndef GYR_CFG_SVH
`define GYR_CFG_SVH

// register byte addresses
`define ADDR_RATE_HI 5'h00
`define ADDR_RATE_LO 5'h01
`define ADDR_TEMP_HI 5'h02
`define ADDR_TEMP_LO 5'h03
`define ADDR_FST_HI 5'h04
`define ADDR_FST_LO 5'h05
`define ADDR_RST_HI 5'h06
`define ADDR_RST_LO 5'h07
`define ADDR_QUAD_HI 5'h08
`define ADDR_QUAD_LO 5'h09
`define ADDR_FAULT_HI 5'h0A
`define ADDR_FAULT_LO 5'h0B
`define ADDR_PART_HI 5'h0C
`define ADDR_PART_LO 5'h0D
`define ADDR_SN3 5'h0E
`define ADDR_SN2 5'h0F
`define ADDR_SN1 5'h10
`define ADDR_SN0 5'h11

// command byte fields
`define CMD_SENSOR_BIT 7
`define CMD_ADDR_MSB 4

// identity values, arbitrary
`define PART_VERSION 16'h4D07
`define UNIT_SERIAL 32'hA5C31E96

// self-test window on the filtered value
`define ST_LIMIT_LO 16'hF830
`define ST_LIMIT_HI 16'h07D0

// refresh dividers of the resonator tick: f0/32, f0/16, f0/64
`define RATE_DIV_MASK 6'h1F
`define ST_DIV_MASK 6'h0F
`define QUAD_DIV_MASK 6'h3F

// link frame edges
`define CMD_LAST_EDGE 6'h07
`define LOAD_EDGE 6'h0F
`define LAST_BIT_EDGE 6'h26
`define FRAME_EDGES 6'h28

// fault set time
`define FAULT_SET_NS 5000
`define MCLK_MHZ 100
`define FAULT_SET_CYC ((`FAULT_SET_NS * `MCLK_MHZ) / 1000)

`endif

// [rtl/gyr_pkg.sv]
// state types of the readout bank
package gyr_pkg;
    typedef struct packed {
        logic [1:0] req_sync;
        logic req_seen;
        logic ack;
        logic [23:0] resp;
        logic [9:0] fs1;
        logic [9:0] fs2;
        logic [10:0] flags;
        logic [15:0] rate;
        logic [9:0] temp;
        logic [15:0] fst;
        logic [15:0] rst;
        logic [15:0] quad;
        logic [5:0] div;
    } gyr_core_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic [7:0] cmd;
        logic req;
        logic [1:0] ack_sync;
        logic [22:0] shift;
        logic miso_out;
        logic miso_oe_n;
    } gyr_link_t;
endpackage

// [rtl/gyr_readout.sv]
// gyroscope register readout: link slave, measurement bank and fault latches
`timescale 1ns/1ps
`include "gyr_cfg.svh"
module gyr_readout (
    // system clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // measurement chain, mclk domain
    input wire logic res_tick,
    input wire logic [15:0] angular_rate_in,
    input wire logic [9:0] die_temperature_in,
    input wire logic [15:0] filtered_selftest_in,
    input wire logic [15:0] raw_selftest_in,
    input wire logic [15:0] motion_error_in,
    // on-chip fault conditions, asynchronous
    input wire logic [3:0] fault_hi_cond,
    input wire logic [4:0] fault_lo_cond,
    input wire logic forced_check_cond,
    // serial link
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_mosi,
    output logic link_miso_out,
    output logic link_miso_oe_n
);
    import gyr_pkg::*;

    localparam int FAULT_LAT = `FAULT_SET_CYC;
    localparam gyr_link_t LINK_IDLE = '{miso_oe_n: 1'b1, default: '0};

    gyr_core_t c;
    gyr_core_t next_c;
    gyr_link_t l;
    gyr_link_t next_l;

    logic req_new;
    logic sens;
    logic [4:0] addr;
    logic fault_clr;
    logic cst_cond;
    logic [7:0] lo_byte;
    logic [15:0] mem_word;
    logic [10:0] set_vec;
    logic [23:0] load_word;

    function automatic logic [7:0] rd_byte(input logic [4:0] a, input gyr_core_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `ADDR_RATE_HI: v = s.rate[15:8];
            `ADDR_RATE_LO: v = s.rate[7:0];
            `ADDR_TEMP_HI: v = s.temp[9:2];
            `ADDR_TEMP_LO: v = {s.temp[1:0], 6'h00};
            `ADDR_FST_HI: v = s.fst[15:8];
            `ADDR_FST_LO: v = s.fst[7:0];
            `ADDR_RST_HI: v = s.rst[15:8];
            `ADDR_RST_LO: v = s.rst[7:0];
            `ADDR_QUAD_HI: v = s.quad[15:8];
            `ADDR_QUAD_LO: v = s.quad[7:0];
            `ADDR_FAULT_HI: v = {4'h0, s.flags[10:7]};
            `ADDR_FAULT_LO: v = {s.flags[6:0], 1'b0};
            `ADDR_PART_HI: v = 8'(`PART_VERSION >> 8);
            `ADDR_PART_LO: v = 8'(`PART_VERSION);
            `ADDR_SN3: v = 8'(`UNIT_SERIAL >> 24);
            `ADDR_SN2: v = 8'(`UNIT_SERIAL >> 16);
            `ADDR_SN1: v = 8'(`UNIT_SERIAL >> 8);
            `ADDR_SN0: v = 8'(`UNIT_SERIAL);
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // command decode; cmd is frozen while the request level is high
    assign req_new = c.req_sync[1] & ~c.req_seen;
    assign sens = l.cmd[`CMD_SENSOR_BIT];
    assign addr = l.cmd[`CMD_ADDR_MSB:0];
    // both halves of the fault word count as a fault read
    assign fault_clr = req_new & (sens | addr == `ADDR_FAULT_HI | addr == `ADDR_FAULT_LO);
    assign cst_cond = ($signed(c.fst) < $signed(`ST_LIMIT_LO)) |
                      ($signed(c.fst) > $signed(`ST_LIMIT_HI));
    assign set_vec = {c.fs2[9:1], cst_cond, c.fs2[0]};
    assign lo_byte = {c.flags[6:0], 1'b0};
    assign mem_word = {rd_byte(addr, c), rd_byte(addr + 5'h01, c)};

    always_comb begin
        next_c = c;
        next_c.req_sync = {c.req_sync[0], l.req};
        next_c.req_seen = c.req_sync[1];
        next_c.fs1 = {fault_hi_cond, fault_lo_cond, forced_check_cond};
        next_c.fs2 = c.fs1;
        if (res_tick) begin
            next_c.div = c.div + 6'h01;
            if ((c.div & `RATE_DIV_MASK) == `RATE_DIV_MASK) begin
                next_c.rate = angular_rate_in;
                next_c.temp = die_temperature_in;
            end
            if ((c.div & `ST_DIV_MASK) == `ST_DIV_MASK) begin
                next_c.fst = filtered_selftest_in;
                next_c.rst = raw_selftest_in;
            end
            if ((c.div & `QUAD_DIV_MASK) == `QUAD_DIV_MASK) begin
                next_c.quad = motion_error_in;
            end
        end
        // set wins over clear, so a persisting fault reappears at once
        next_c.flags = (fault_clr ? 11'h000 : c.flags) | set_vec;
        if (req_new) begin
            next_c.ack = 1'b1;
            if (sens) begin
                next_c.resp = {c.rate, lo_byte};
            end else begin
                next_c.resp = {mem_word, 8'h00};
            end
        end else if (!c.req_sync[1]) begin
            next_c.ack = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    // link side: word handed over only once the acknowledge has settled
    assign load_word = l.ack_sync[1] ? c.resp : 24'h000000;

    always_comb begin
        next_l = l;
        next_l.ack_sync = {l.ack_sync[0], c.ack};
        if (l.cnt != `FRAME_EDGES) begin
            next_l.cnt = l.cnt + 6'h01;
        end
        if (l.cnt <= `CMD_LAST_EDGE) begin
            next_l.cmd = {l.cmd[6:0], link_mosi};
        end
        if (l.cnt == `CMD_LAST_EDGE) begin
            next_l.req = 1'b1;
        end
        if (l.cnt == `LOAD_EDGE) begin
            next_l.miso_out = load_word[23];
            next_l.shift = load_word[22:0];
            next_l.miso_oe_n = 1'b0;
        end else if (l.cnt > `LOAD_EDGE && l.cnt <= `LAST_BIT_EDGE) begin
            next_l.miso_out = l.shift[22];
            next_l.shift = {l.shift[21:0], 1'b0};
        end else if (l.cnt > `LAST_BIT_EDGE) begin
            next_l.miso_out = 1'b0;
            next_l.miso_oe_n = 1'b1;
        end
    end

    // the frame select ends every frame, as the link clock stops between frames
    always_ff @(posedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            l <= LINK_IDLE;
        end else begin
            l <= next_l;
        end
    end

    assign link_miso_out = l.miso_out;
    assign link_miso_oe_n = l.miso_oe_n;

    // checks, system clock domain
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence mem_read_req;
        req_new && !sens;
    endsequence

    sequence fault_held;
        $rose(fault_hi_cond[2]) ##1 fault_hi_cond[2] [*3];
    endsequence

    AST_RESP_PAIR: assert property (
        mem_read_req |=> c.resp == {$past(mem_word), 8'h00} && c.ack)
        else $error("memory read word not addressed byte then next byte");

    AST_SENSOR_RESP: assert property (
        (req_new && sens) |=> c.resp[23:16] == $past(c.rate[15:8]) &&
            c.resp[15:8] == $past(c.rate[7:0]) && c.resp[7:0] == $past(lo_byte))
        else $error("sensor response not rate plus low fault byte");

    AST_RATE_REFRESH: assert property (
        (c.rate != $past(c.rate)) |-> $past(res_tick) && $past(c.div[4:0]) == 5'h1F)
        else $error("rate changed off its refresh tick");

    AST_QUAD_REFRESH: assert property (
        (c.quad != $past(c.quad)) |-> $past(res_tick) && $past(c.div) == 6'h3F)
        else $error("quadrature changed off its refresh tick");

    AST_CST_CAUSE: assert property (
        $rose(c.flags[1]) |-> $past(cst_cond))
        else $error("self-test fault set without filtered value outside limits");

    AST_FAULT_SET: assert property (
        fault_held |-> ##[0:FAULT_LAT] c.flags[9])
        else $error("fault flag not set within its set time");

    AST_FLAG_HOLD: assert property (
        $fell(c.flags[10]) |-> $past(fault_clr))
        else $error("fault flag dropped without a clearing read");

    AST_REASSERT: assert property (
        (fault_clr && c.fs2[9]) |=> c.flags[10])
        else $error("persisting fault not set again after clear");

    AST_TEMP_LOW: assert property (
        (mem_read_req and addr == `ADDR_TEMP_HI) |=> c.resp[13:8] == 6'h00)
        else $error("temperature low field not zero");

    AST_FAULT_LAYOUT: assert property (
        (mem_read_req and addr == `ADDR_FAULT_HI) |=>
            c.resp[23:20] == 4'h0 && c.resp[8] == 1'b0)
        else $error("fault word unused bits not zero");

    AST_PART_VERSION: assert property (
        (mem_read_req and addr == `ADDR_PART_HI) |=> c.resp[23:8] == `PART_VERSION)
        else $error("part version word wrong");

    AST_FST_REFRESH: assert property (
        (c.fst != $past(c.fst)) |->
            $past(res_tick) && $past(c.div[3:0]) == 4'hF)
        else $error("filtered self-test changed off its refresh tick");

    AST_RAW_REFRESH: assert property (
        (c.rst != $past(c.rst)) |->
            $past(res_tick) && $past(c.div[3:0]) == 4'hF)
        else $error("raw self-test changed off its refresh tick");

    AST_TEMP_REFRESH: assert property (
        (c.temp != $past(c.temp)) |->
            $past(res_tick) && $past(c.div[4:0]) == 5'h1F)
        else $error("temperature changed off its refresh tick");

    AST_RATE_TAKE: assert property (
        (res_tick && c.div[4:0] == 5'h1F) |=>
            c.rate == $past(angular_rate_in))
        else $error("rate not taken on its refresh tick");

    AST_FST_TAKE: assert property (
        (res_tick && c.div[3:0] == 4'hF) |=>
            c.fst == $past(filtered_selftest_in))
        else $error("filtered self-test not taken on its refresh tick");

    AST_RAW_TAKE: assert property (
        (res_tick && c.div[3:0] == 4'hF) |=>
            c.rst == $past(raw_selftest_in))
        else $error("raw self-test not taken on its refresh tick");

    AST_QUAD_TAKE: assert property (
        (res_tick && c.div == 6'h3F) |=>
            c.quad == $past(motion_error_in))
        else $error("quadrature not taken on its refresh tick");

    AST_CST_SET: assert property (
        cst_cond |=>
            c.flags[1])
        else $error("self-test fault not set with filtered value outside limits");

    AST_FLAG_SET: assert property (
        (set_vec != 11'h000) |=>
            (c.flags & $past(set_vec)) == $past(set_vec))
        else $error("present fault condition not latched");

    AST_CLEAR: assert property (
        (fault_clr && set_vec == 11'h000) |=>
            c.flags == 11'h000)
        else $error("fault flags not cleared by a clearing read");

    AST_NO_SIDE: assert property (
        (req_new && !fault_clr) |=>
            c.flags == ($past(c.flags) | $past(set_vec)))
        else $error("plain read disturbed the fault flags");

    AST_FAULT_LO_BIT0: assert property (
        (mem_read_req and addr == `ADDR_FAULT_LO) |=>
            c.resp[16] == 1'b0)
        else $error("low fault byte bit zero not zero");

    AST_SENSOR_BIT0: assert property (
        (req_new && sens) |=>
            c.resp[0] == 1'b0)
        else $error("appended fault byte bit zero not zero");

    AST_SERIAL_HI: assert property (
        (mem_read_req and addr == `ADDR_SN3) |=>
            c.resp[23:8] == 16'(`UNIT_SERIAL >> 16))
        else $error("upper serial half wrong");

    AST_RESP_HOLD: assert property (
        !req_new |=>
            $stable(c.resp))
        else $error("response word changed without a request");

    AST_ACK_HOLD: assert property (
        (c.ack && c.req_sync[1]) |=>
            c.ack)
        else $error("acknowledge dropped while request stands");

    // checks, link clock domain
    AST_MSB_FIRST: assert property (
        @(posedge link_sclk) disable iff (link_cs_n)
        (l.cnt == `LOAD_EDGE && l.ack_sync[1]) |=>
            l.miso_out == c.resp[23] ##1 l.miso_out == c.resp[22])
        else $error("read data not shifted msb first");

    AST_CMD_REQ: assert property (
        @(posedge link_sclk) disable iff (link_cs_n)
        (l.cnt == `CMD_LAST_EDGE) |=> l.req)
        else $error("request not raised after the command byte");

    AST_OE_DRIVE: assert property (
        @(posedge link_sclk) disable iff (link_cs_n)
        (l.cnt == `LOAD_EDGE) |=> !l.miso_oe_n)
        else $error("response line not driven from its load edge");

    AST_IDLE_LOW: assert property (
        @(posedge link_sclk) disable iff (link_cs_n)
        l.miso_oe_n |-> !l.miso_out)
        else $error("response bit not low while released");
endmodule

// [verification/gyr_host.sv]
// link master model issuing register and sensor read frames
`timescale 1ns/1ps
module gyr_host (
    // link toward the device
    output logic link_sclk,
    output logic link_cs_n,
    output logic link_mosi,
    input wire logic link_miso_out,
    input wire logic link_miso_oe_n
);
    int oe_err;
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_mosi = 1'b0;
        oe_err = 0;
    end
    // clock stands low outside frames; mosi toggles once released
    task automatic xfer(input logic [7:0] cmd, output logic [23:0] resp);
        int i;
        resp = 24'h000000;
        #7 link_cs_n = 1'b0;
        for (i = 0; i < 40; i++) begin
            #40;
            if (i < 8) link_mosi = cmd[7 - i];
            else link_mosi = ~link_mosi;
            #40 link_sclk = 1'b1;
            #80 link_sclk = 1'b0;
            if (i >= 15 && i <= 38) begin
                resp = {resp[22:0], link_miso_out};
                if (link_miso_oe_n !== 1'b0) oe_err++;
            end
        end
        #80 link_cs_n = 1'b1;
        link_mosi = ~link_mosi;
        #80;
    endtask
endmodule

// [verification/gyr_readout_tb_top.sv]
// self-checking bench of the readout bank
`timescale 1ns/1ps
`include "gyr_cfg.svh"
module gyr_readout_tb_top;
    localparam logic [15:0] PV = `PART_VERSION;
    localparam logic [31:0] SN = `UNIT_SERIAL;
    localparam logic [23:0] ALL = 24'hFFFFFF;
    logic mclk, rstn, res_tick, chk_cond;
    logic [15:0] rate, fst, rst, quad;
    logic [9:0] temp;
    logic [3:0] hi_cond;
    logic [4:0] lo_cond;
    logic sclk, cs_n, mosi, miso, oe_n;
    int n_fail = 0;
    int compares = 0;

    gyr_readout uut (.mclk(mclk), .rstn(rstn), .res_tick(res_tick),
        .angular_rate_in(rate), .die_temperature_in(temp),
        .filtered_selftest_in(fst), .raw_selftest_in(rst),
        .motion_error_in(quad), .fault_hi_cond(hi_cond),
        .fault_lo_cond(lo_cond), .forced_check_cond(chk_cond),
        .link_sclk(sclk), .link_cs_n(cs_n), .link_mosi(mosi),
        .link_miso_out(miso), .link_miso_oe_n(oe_n));
    gyr_host host (.link_sclk(sclk), .link_cs_n(cs_n), .link_mosi(mosi),
        .link_miso_out(miso), .link_miso_oe_n(oe_n));

    task stop_test;
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] a, input logic [23:0] exp, input logic [23:0] m);
        logic [23:0] r;
        host.xfer(a, r);
        chk(r & m, exp & m);
    endtask
    task ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1 res_tick = 1'b1;
            @(posedge mclk);
            #1 res_tick = 1'b0;
        end
    endtask
    task waitc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #800us;
        n_fail++;
        stop_test;
    end
    initial begin
        rstn = 1'b0;
        res_tick = 1'b0;
        rate = 16'h5DC0;
        temp = 10'h320;
        fst = 16'h0100;
        rst = 16'h8000;
        quad = 16'hFC18;
        hi_cond = 4'h0;
        lo_cond = 5'h00;
        chk_cond = 1'b0;
        waitc(20);
        rstn = 1'b1;
        waitc(3);
        ticks(64);
        rd(8'h0A, 24'h0, ALL);
        rd(8'h00, {16'h5DC0, 8'h00}, ALL);
        rd(8'h02, {10'h320, 14'h0}, 24'hFFC000);
        rd(8'h04, {16'h0100, 8'h00}, ALL);
        rd(8'h06, {16'h8000, 8'h00}, ALL);
        rd(8'h08, {16'hFC18, 8'h00}, ALL);
        rd(8'h0B, {8'h00, PV[15:8], 8'h00}, ALL);
        rd(8'h0C, {PV, 8'h00}, ALL);
        rd(8'h0E, {SN[31:16], 8'h00}, ALL);
        rd(8'h10, {SN[15:0], 8'h00}, ALL);
        rd(8'h11, {SN[7:0], 16'h0}, ALL);
        rd(8'h15, 24'h0, ALL);
        rd(8'h80, {16'h5DC0, 8'h00}, ALL);
        waitc(1);
        rate = 16'h2710;
        quad = 16'h03E8;
        ticks(31);
        rd(8'h00, {16'h5DC0, 8'h00}, ALL);
        ticks(1);
        rd(8'h00, {16'h2710, 8'h00}, ALL);
        rd(8'h08, {16'hFC18, 8'h00}, ALL);
        ticks(32);
        rd(8'h08, {16'h03E8, 8'h00}, ALL);
        waitc(1);
        hi_cond = 4'h5;
        lo_cond = 5'h11;
        chk_cond = 1'b1;
        waitc(500);
        hi_cond = 4'h0; // next read still sees the latched flags
        rd(8'h0A, {8'h05, 8'h8A, 8'h00}, ALL);
        waitc(1);
        lo_cond = 5'h00;
        chk_cond = 1'b0;
        rd(8'h0A, {8'h00, 8'h8A, 8'h00}, ALL);
        rd(8'h0A, 24'h0, ALL);
        waitc(1);
        lo_cond = 5'h02;
        waitc(500);
        lo_cond = 5'h00;
        rd(8'h00, {16'h2710, 8'h00}, ALL);
        rd(8'h80, {16'h2710, 8'h10}, ALL);
        rd(8'h0A, 24'h0, ALL);
        waitc(1);
        fst = 16'h7FFF;
        ticks(16);
        waitc(500);
        rd(8'h0B, {8'h04, PV[15:8], 8'h00}, ALL);
        chk(24'(host.oe_err), 24'h0);
        stop_test;
    end
endmodule
